/* File: ref_map_pkg.sv */
// constants for the remote voltage reference selection map
`default_nettype none
package ref_map_pkg;

	// =========================================================
	// word indices; the byte address on the bus is four times the index
	localparam logic [5:0] IDX_VOLT_KNOB          = 6'h20;
	localparam logic [5:0] IDX_STABILITY_KNOB     = 6'h21;
	localparam logic [5:0] IDX_FREQUENCY_KNOB     = 6'h22;
	localparam logic [5:0] IDX_CURRENT_KNOB       = 6'h23;
	localparam logic [5:0] IDX_REGULATED_VOLTAGE  = 6'h24;
	localparam logic [5:0] IDX_MEASURED_FREQUENCY = 6'h25;
	localparam logic [5:0] IDX_ACTIVE_ALARMS      = 6'h26;
	localparam logic [5:0] IDX_ACTIVE_CONFIG      = 6'h27;
	localparam logic [5:0] IDX_RESERVED_COMMAND   = 6'h28;
	localparam logic [5:0] IDX_EXTERNAL_INPUT     = 6'h29;
	localparam logic [5:0] IDX_SETPOINT           = 6'h2A;
	localparam logic [5:0] IDX_EFFECTIVE_SETPOINT = 6'h2B;
	localparam logic [5:0] IDX_MEASURED_VOLTAGE   = 6'h2C;
	localparam logic [5:0] IDX_EXCITER_TEMP       = 6'h2D;
	localparam logic [5:0] IDX_REMOTE_REFERENCE   = 6'h31;
	localparam logic [5:0] IDX_PROP_GAIN          = 6'h35;
	localparam logic [5:0] IDX_INTEG_GAIN         = 6'h36;
	localparam logic [5:0] IDX_OVEREXC_THRESHOLD  = 6'h37;
	localparam logic [5:0] IDX_UNDEREXC_OBSERVER  = 6'h38;
	// parameter words held in this block
	localparam logic [5:0] IDX_CONFIG_WORD        = 6'h0A;
	localparam logic [5:0] IDX_NV_REFERENCE       = 6'h0F;
	localparam logic [5:0] IDX_RANGE_PARAM        = 6'h10;

	// =========================================================
	// configuration word fields
	localparam int REFERENCE_FLAG_BIT = 7;
	localparam int INPUT_ENABLE_BIT   = 12;

	// =========================================================
	// values after reset and scaling constants
	localparam logic [15:0] CONFIG_WORD_RST  = 16'h1F3D;
	localparam logic [15:0] NV_REFERENCE_RST = 16'h4000;
	localparam logic [15:0] RANGE_PARAM_RST  = 16'h000E;
	localparam logic [15:0] REFERENCE_MID    = 16'h4000;
	localparam logic [15:0] PERCENT_FULL     = 16'h0064;

	// =========================================================
	// output voltage control type
	typedef enum logic [1:0]
	{
		MODE_ANALOG_FREE = 2'b00,
		MODE_ANALOG_SAT  = 2'b01,
		MODE_PARAMETER   = 2'b10,
		MODE_RAM_WORD    = 2'b11
	} control_mode_type;

endpackage
`default_nettype wire

/* File: ref_sel_if.sv */
// signals between the register map and the reference selector
`timescale 1ns/10ps
`default_nettype none
interface ref_sel_if;
	logic [15:0]                     config_word;
	logic [15:0]                     nv_reference;
	logic [15:0]                     range_param;
	logic [15:0]                     ram_reference;
	logic [15:0]                     input_level;
	logic [15:0]                     input_limit;
	logic                            link_lost;
	logic [15:0]                     command;
	ref_map_pkg::control_mode_type   mode;

	modport map_side
	(
		output config_word,
		output nv_reference,
		output range_param,
		output ram_reference,
		output input_level,
		output input_limit,
		output link_lost,
		input  command,
		input  mode
	);

	modport selector
	(
		input  config_word,
		input  nv_reference,
		input  range_param,
		input  ram_reference,
		input  input_level,
		input  input_limit,
		input  link_lost,
		output command,
		output mode
	);
endinterface
`default_nettype wire

/* File: ref_selector.sv */
// chooses the output voltage command from the two configuration flags
`timescale 1ns/10ps
`default_nettype none
module ref_selector
(
	ref_sel_if.selector sel
);

	// =========================================================
	// mode decode
	wire         ram_flag;
	wire         input_enable;
	wire         at_limit;
	wire [31:0]  offset_wide;
	wire [15:0]  max_offset_cmd;
	wire [15:0]  analog_sat_cmd;

	assign ram_flag     = sel.config_word[ref_map_pkg::REFERENCE_FLAG_BIT];  // RL1
	assign input_enable = sel.config_word[ref_map_pkg::INPUT_ENABLE_BIT];    // RL2

	assign sel.mode = input_enable
		? (ram_flag ? ref_map_pkg::MODE_ANALOG_SAT : ref_map_pkg::MODE_ANALOG_FREE)
		: (ram_flag ? ref_map_pkg::MODE_RAM_WORD : ref_map_pkg::MODE_PARAMETER);

	// =========================================================
	// saturation: clamp at the input limit, full positive offset on lost link
	assign at_limit       = sel.input_level >= sel.input_limit;
	assign offset_wide    = ({16'h0000, sel.range_param} * {16'h0000, ref_map_pkg::REFERENCE_MID})
		/ {16'h0000, ref_map_pkg::PERCENT_FULL};
	assign max_offset_cmd = ref_map_pkg::REFERENCE_MID + offset_wide[15:0];              // RL4
	assign analog_sat_cmd = sel.link_lost ? max_offset_cmd                               // RL4
		: (at_limit ? sel.input_limit : sel.input_level);                                // RL3

	// =========================================================
	// command selection
	always_comb
	begin
		case (sel.mode)
			ref_map_pkg::MODE_ANALOG_FREE: sel.command = sel.input_level;               // RL3
			ref_map_pkg::MODE_ANALOG_SAT:  sel.command = analog_sat_cmd;                // RL3
			ref_map_pkg::MODE_PARAMETER:   sel.command = sel.nv_reference;              // RL5
			ref_map_pkg::MODE_RAM_WORD:    sel.command = sel.ram_reference;             // RL8
			default:                       sel.command = sel.nv_reference;
		endcase
	end

endmodule
`default_nettype wire

/* File: remote_voltage_ref_select_map.sv */
// register map and remote voltage reference control, reached over AHB-Lite
//
// What this block does
// RL1: bit 7 of configuration is reference flag
// RL2: bit 12 of configuration enables analogue input
// RL3: analogue mode with flag clamps at limit
// RL4: lost input in saturation drives maximum offset
// RL5: digital mode, flag clear uses stored parameter
// RL6: reference word loaded, then tracks parameter in parameter mode
// RL7: writes to reference word ignored in parameter mode
// RL8: digital mode, flag set uses reference word
// RL9: regulated voltage readable at word 36
// RL10: measured frequency readable at word 37
// RL11: supervisor never writes command word 40
// RL12: external input reading at word 41
// RL13: effective setpoint readable at word 43
// RL14: exciter temperature estimate at word 45
// RL15: unscaled gains readable at words 53, 54
// RL16: overexcitation threshold readable at word 55
// RL17: underexcitation observer readable at word 56
// RL18: word 49 acts only in RAM mode
// RL19: status bit 7 shows remote control or saturation
// RL20: writes to read-only words are ignored
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module remote_voltage_ref_select_map
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,

	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic [31:0]       hrdata,
	output logic              hresp,

	// knob positions from the regulator core
	input  wire logic [15:0]  volt_knob_position,
	input  wire logic [15:0]  stability_knob_position,
	input  wire logic [15:0]  frequency_knob_position,
	input  wire logic [15:0]  excitation_current_knob_position,

	// measured and computed values from the regulator core
	input  wire logic [15:0]  regulated_voltage,
	input  wire logic [15:0]  measured_frequency,
	input  wire logic [15:0]  active_alarms,
	input  wire logic [15:0]  setpoint_value,
	input  wire logic [15:0]  effective_setpoint,
	input  wire logic [15:0]  measured_voltage_internal,
	input  wire logic [15:0]  exciter_temperature_estimate,
	input  wire logic [15:0]  proportional_gain_unscaled,
	input  wire logic [15:0]  integral_gain_unscaled,
	input  wire logic [15:0]  overexcitation_threshold,
	input  wire logic [15:0]  underexcitation_observer,

	// external analogue input
	input  wire logic [15:0]  external_input_value,
	input  wire logic [15:0]  external_input_limit,
	input  wire logic         external_link_lost,

	// voltage reference out to the regulator core
	output logic [15:0]       voltage_command,
	output logic [1:0]        control_mode
);

	// =========================================================
	// declarations
	ref_sel_if sel_bus ();

	logic         lost_meta_r;
	logic         lost_sync_r;
	logic         startup_load_r;
	logic [15:0]  config_word_r;
	logic [15:0]  nv_reference_r;
	logic [15:0]  range_param_r;
	logic [15:0]  remote_reference_r;
	logic [15:0]  remote_reference_nxt;
	logic [15:0]  reserved_command_r;
	logic         wr_pending_r;
	logic [5:0]   wr_index_r;
	logic [15:0]  voltage_command_r;
	logic [1:0]   control_mode_r;
	logic [31:0]  hrdata_r;
	logic         hreadyout_r;
	logic         hresp_r;

	wire          addr_phase;
	wire          rd_take;
	wire          wr_take;
	wire [5:0]    rd_index;
	wire          rd_mapped;
	wire [15:0]   rd_word;
	wire [15:0]   wr_value;
	wire          wr_config;
	wire          wr_nv_reference;
	wire          wr_range;
	wire          wr_remote_ref;
	wire          wr_reserved;
	wire          param_mode;

	// =========================================================
	// address decode
	function automatic logic [5:0] word_index(input logic [31:0] addr);
		word_index = addr[7:2];
	endfunction

	function automatic logic in_map(input logic [31:0] addr);
		in_map = (addr[31:8] == 24'h000000) && (addr[1:0] == 2'b00);
	endfunction

	assign addr_phase = hsel && htrans[1] && hready;
	assign rd_take    = addr_phase && !hwrite;
	assign wr_take    = addr_phase && hwrite && in_map(haddr);  // RL20
	assign rd_index   = word_index(haddr);
	assign rd_mapped  = in_map(haddr);
	assign wr_value   = hwdata[15:0];

	// only the parameter words, the reference word and the command word take
	// writes; every read-only word but the active configuration stays driven by the core
	assign wr_config       = wr_pending_r && (wr_index_r == ref_map_pkg::IDX_CONFIG_WORD);
	assign wr_nv_reference = wr_pending_r && (wr_index_r == ref_map_pkg::IDX_NV_REFERENCE);
	assign wr_range        = wr_pending_r && (wr_index_r == ref_map_pkg::IDX_RANGE_PARAM);
	assign wr_remote_ref   = wr_pending_r && (wr_index_r == ref_map_pkg::IDX_REMOTE_REFERENCE);
	assign wr_reserved     = wr_pending_r && (wr_index_r == ref_map_pkg::IDX_RESERVED_COMMAND);

	// =========================================================
	// read selection
	function automatic logic [15:0] read_mux(input logic [5:0] idx);
		case (idx)
			ref_map_pkg::IDX_VOLT_KNOB:          read_mux = volt_knob_position;
			ref_map_pkg::IDX_STABILITY_KNOB:     read_mux = stability_knob_position;
			ref_map_pkg::IDX_FREQUENCY_KNOB:     read_mux = frequency_knob_position;
			ref_map_pkg::IDX_CURRENT_KNOB:       read_mux = excitation_current_knob_position;
			ref_map_pkg::IDX_REGULATED_VOLTAGE:  read_mux = regulated_voltage;            // RL9
			ref_map_pkg::IDX_MEASURED_FREQUENCY: read_mux = measured_frequency;           // RL10
			ref_map_pkg::IDX_ACTIVE_ALARMS:      read_mux = active_alarms;
			ref_map_pkg::IDX_ACTIVE_CONFIG:      read_mux = config_word_r;                // RL19
			ref_map_pkg::IDX_EXTERNAL_INPUT:     read_mux = external_input_value;         // RL12
			ref_map_pkg::IDX_SETPOINT:           read_mux = setpoint_value;
			ref_map_pkg::IDX_EFFECTIVE_SETPOINT: read_mux = effective_setpoint;           // RL13
			ref_map_pkg::IDX_MEASURED_VOLTAGE:   read_mux = measured_voltage_internal;
			ref_map_pkg::IDX_EXCITER_TEMP:       read_mux = exciter_temperature_estimate; // RL14
			ref_map_pkg::IDX_REMOTE_REFERENCE:   read_mux = remote_reference_r;
			ref_map_pkg::IDX_PROP_GAIN:          read_mux = proportional_gain_unscaled;   // RL15
			ref_map_pkg::IDX_INTEG_GAIN:         read_mux = integral_gain_unscaled;       // RL15
			ref_map_pkg::IDX_OVEREXC_THRESHOLD:  read_mux = overexcitation_threshold;     // RL16
			ref_map_pkg::IDX_UNDEREXC_OBSERVER:  read_mux = underexcitation_observer;     // RL17
			ref_map_pkg::IDX_CONFIG_WORD:        read_mux = config_word_r;
			ref_map_pkg::IDX_NV_REFERENCE:       read_mux = nv_reference_r;
			ref_map_pkg::IDX_RANGE_PARAM:        read_mux = range_param_r;
			default:                             read_mux = 16'h0000;
		endcase
	endfunction

	assign rd_word = rd_mapped ? read_mux(rd_index) : 16'h0000;

	// =========================================================
	// reference word: tracks the parameter in parameter mode only
	assign param_mode = (sel_bus.mode == ref_map_pkg::MODE_PARAMETER);

	// the command word is latched but steers nothing
	assign remote_reference_nxt =
		startup_load_r ? nv_reference_r :                                            // RL6
		param_mode     ? nv_reference_r :                                            // RL6 RL7
		wr_remote_ref  ? wr_value       :                                            // RL18
		remote_reference_r;

	// =========================================================
	// selector hookup
	assign sel_bus.config_word   = config_word_r;
	assign sel_bus.nv_reference  = nv_reference_r;
	assign sel_bus.range_param   = range_param_r;
	assign sel_bus.ram_reference = remote_reference_r;
	assign sel_bus.input_level   = external_input_value;
	assign sel_bus.input_limit   = external_input_limit;
	assign sel_bus.link_lost     = lost_sync_r;

	ref_selector u_selector
	(
		.sel (sel_bus.selector)
	);

	// =========================================================
	// lost-link pin synchroniser
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lost_meta_r <= 1'b0;
			lost_sync_r <= 1'b0;
		end
		else
		begin
			lost_meta_r <= external_link_lost;
			lost_sync_r <= lost_meta_r;
		end
	end

	// =========================================================
	// bus phase tracking
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pending_r <= 1'b0;
			wr_index_r   <= 6'h00;
		end
		else
		begin
			wr_pending_r <= wr_take;
			wr_index_r   <= rd_index;
		end
	end

	// read data is taken in the address phase and stands until the next read
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hrdata_r <= 32'h00000000;
		end
		else if (rd_take)
		begin
			hrdata_r <= {16'h0000, rd_word};
		end
	end

	// zero wait states from the first edge after reset; response always okay
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hreadyout_r <= 1'b0;
			hresp_r     <= 1'b0;
		end
		else
		begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	// =========================================================
	// parameter words and the command word
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_word_r <= ref_map_pkg::CONFIG_WORD_RST;
		end
		else if (wr_config)
		begin
			config_word_r <= wr_value;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nv_reference_r <= ref_map_pkg::NV_REFERENCE_RST;
		end
		else if (wr_nv_reference)
		begin
			nv_reference_r <= wr_value;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			range_param_r <= ref_map_pkg::RANGE_PARAM_RST;
		end
		else if (wr_range)
		begin
			range_param_r <= wr_value;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reserved_command_r <= 16'h0000;
		end
		else if (wr_reserved)
		begin
			reserved_command_r <= wr_value;
		end
	end

	// =========================================================
	// start-up load strobe: high for the first edge after reset only
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			startup_load_r <= 1'b1;
		end
		else
		begin
			startup_load_r <= 1'b0;
		end
	end

	// reference word
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			remote_reference_r <= 16'h0000;
		end
		else
		begin
			remote_reference_r <= remote_reference_nxt;
		end
	end

	// command and mode are registered so the core sees clean levels
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			voltage_command_r <= 16'h0000;
			control_mode_r    <= 2'b00;
		end
		else
		begin
			voltage_command_r <= sel_bus.command;
			control_mode_r    <= sel_bus.mode;
		end
	end

	assign hreadyout       = hreadyout_r;
	assign hrdata          = hrdata_r;
	assign hresp           = hresp_r;
	assign voltage_command = voltage_command_r;
	assign control_mode    = control_mode_r;

endmodule
`default_nettype wire

/* File: supervisor_model.sv */
// supervisor model: AHB-Lite master doing single word transfers
`timescale 1ns/10ps
`default_nettype none
module supervisor_model
(
	// clock and answer
	input  wire logic        ref_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// request
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// writes to the reserved command word are dropped here without a bus transfer; reads go through
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		if (w && a[7:2] == ref_map_pkg::IDX_RESERVED_COMMAND)
			return;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: ref_map_monitor.sv */
// assertions on the ports of the reference selection map
`timescale 1ns/10ps
`default_nettype none
module ref_map_monitor
(
	// clock, reset, bus
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// core side
	input wire logic [15:0] regulated_voltage,
	input wire logic [15:0] measured_frequency,
	input wire logic [15:0] effective_setpoint,
	input wire logic [15:0] external_input_value,
	input wire logic [15:0] external_input_limit,
	input wire logic        external_link_lost,
	input wire logic [15:0] voltage_command,
	input wire logic [1:0]  control_mode
);
	// ========
	// helpers
	localparam int MID = int'(ref_map_pkg::REFERENCE_MID);
	localparam logic [15:0] LOST_CMD = 16'(MID + MID * int'(ref_map_pkg::RANGE_PARAM_RST) / 100);
	wire take = hsel && htrans[1] && hready && haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0;
	wire rd = take && !hwrite;
	wire [5:0] idx = haddr[7:2];
	wire [15:0] sat = (external_input_value > external_input_limit) ?
		external_input_limit : external_input_value;
	logic [2:0] lo_r;
	logic [2:0] hi_r;
	logic       wcfg_r;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lo_r <= 3'h0;
			hi_r <= 3'h0;
			wcfg_r <= 1'b0;
		end
		else
		begin
			lo_r <= external_link_lost ? 3'h0 : lo_r + 3'(lo_r != 3'h7);
			hi_r <= external_link_lost ? hi_r + 3'(hi_r != 3'h7) : 3'h0;
			wcfg_r <= take && hwrite && idx == ref_map_pkg::IDX_CONFIG_WORD;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ========
	// assertions
	property p_mode;
		wcfg_r |-> ##2 control_mode == {~$past(hwdata[12], 2), $past(hwdata[7], 2)};
	endproperty
	a_mode: assert property (p_mode) else $error("mode not from config");
	property p_sat;
		control_mode == 2'h1 && $past(lo_r) >= 3'h4 |-> voltage_command == $past(sat);
	endproperty
	a_sat: assert property (p_sat) else $error("saturation wrong");
	property p_lost;
		control_mode == 2'h1 && $past(hi_r) >= 3'h4 |-> voltage_command == LOST_CMD;
	endproperty
	a_lost: assert property (p_lost) else $error("lost input command wrong");
	property p_volt;
		rd && idx == ref_map_pkg::IDX_REGULATED_VOLTAGE
		|=> hrdata == {16'h0, $past(regulated_voltage)};
	endproperty
	a_volt: assert property (p_volt) else $error("voltage word wrong");
	property p_freq;
		rd && idx == ref_map_pkg::IDX_MEASURED_FREQUENCY
		|=> hrdata == {16'h0, $past(measured_frequency)};
	endproperty
	a_freq: assert property (p_freq) else $error("frequency word wrong");
	property p_ext;
		rd && idx == ref_map_pkg::IDX_EXTERNAL_INPUT
		|=> hrdata == {16'h0, $past(external_input_value)};
	endproperty
	a_ext: assert property (p_ext) else $error("input word wrong");
	property p_eff;
		rd && idx == ref_map_pkg::IDX_EFFECTIVE_SETPOINT
		|=> hrdata == {16'h0, $past(effective_setpoint)};
	endproperty
	a_eff: assert property (p_eff) else $error("setpoint word wrong");
	property p_status;
		rd && idx == ref_map_pkg::IDX_ACTIVE_CONFIG |=> hrdata[7] == control_mode[0];
	endproperty
	a_status: assert property (p_status) else $error("status bit 7 wrong");
endmodule
bind remote_voltage_ref_select_map ref_map_monitor mon (.*);
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the reference selection map
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ========
	// signals
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic        lost = 1'b0;
	logic [1:0]  htrans;
	logic [1:0]  control_mode;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [15:0] lim = 16'h3000;
	logic [15:0] voltage_command;
	logic [15:0] cv [16];
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	localparam logic [5:0] RO_IDX [16] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26,
		6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h35, 6'h36, 6'h37, 6'h38, 6'h29};
	localparam int MID = int'(ref_map_pkg::REFERENCE_MID);
	localparam logic [15:0] LOST_CMD = 16'(MID + MID * int'(ref_map_pkg::RANGE_PARAM_RST) / 100);

	always #12.5 ref_clk = ~ref_clk;

	remote_voltage_ref_select_map dut
	(
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.volt_knob_position(cv[0]), .stability_knob_position(cv[1]),
		.frequency_knob_position(cv[2]), .excitation_current_knob_position(cv[3]),
		.regulated_voltage(cv[4]), .measured_frequency(cv[5]), .active_alarms(cv[6]),
		.setpoint_value(cv[7]), .effective_setpoint(cv[8]),
		.measured_voltage_internal(cv[9]), .exciter_temperature_estimate(cv[10]),
		.proportional_gain_unscaled(cv[11]), .integral_gain_unscaled(cv[12]),
		.overexcitation_threshold(cv[13]), .underexcitation_observer(cv[14]),
		.external_input_value(cv[15]), .external_input_limit(lim),
		.external_link_lost(lost), .voltage_command(voltage_command),
		.control_mode(control_mode)
	);

	supervisor_model sup
	(
		.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
	);

	// ========
	// expectations and bus tasks
	function automatic logic [15:0] cfg(input int m);
		cfg = ref_map_pkg::CONFIG_WORD_RST;
		cfg[12] = ~m[1];
		cfg[7] = m[0];
	endfunction

	function automatic logic [15:0] want(input int m, input logic [15:0] x, input logic [15:0] nv);
		if (m == 0)
			return x;
		if (m == 1)
			return (x > lim) ? lim : x;
		if (m == 2)
			return nv;
		return x ^ 16'h5A5A;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] e);
		tests_run++;
		if (got !== e)
		begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [5:0] i, input logic [15:0] d);
		sup.xfer(1'b1, {24'h0, i, 2'h0}, {16'h0, d}, rd);
		@(posedge ref_clk);
	endtask

	task automatic rdw(input logic [5:0] i, input logic [15:0] e);
		sup.xfer(1'b0, {24'h0, i, 2'h0}, 32'h0, rd);
		check(rd, {16'h0, e});
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic cmd(input logic [15:0] e);
		@(negedge ref_clk);
		check({16'h0, voltage_command}, {16'h0, e});
		@(posedge ref_clk);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			$display("ERROR %0t timeout", $time);
			print_verdict();
		end
	end

	// ========
	// main sequence
	initial
	begin
		logic [15:0] x;
		logic [15:0] nv;
		void'($urandom(32'h8185));
		nv = ref_map_pkg::NV_REFERENCE_RST;
		foreach (cv[i])
			cv[i] = 16'($urandom);
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rdw(ref_map_pkg::IDX_REMOTE_REFERENCE, nv);
		rdw(ref_map_pkg::IDX_ACTIVE_CONFIG, ref_map_pkg::CONFIG_WORD_RST);
		repeat (3)
		begin
			foreach (cv[i])
				cv[i] <= 16'($urandom);
			@(posedge ref_clk);
			foreach (RO_IDX[i])
				rdw(RO_IDX[i], cv[i]);
		end
		wr(ref_map_pkg::IDX_REGULATED_VOLTAGE, ~cv[4]);
		rdw(ref_map_pkg::IDX_REGULATED_VOLTAGE, cv[4]);
		wr(6'h3F, 16'hFFFF);
		rdw(6'h3F, 16'h0);
		sup.xfer(1'b0, 32'h0000_0190, 32'h0, rd);
		check(rd, 32'h0);
		repeat (3)
		begin
			for (int m = 0; m < 4; m++)
			begin
				x = 16'($urandom);
				wr(ref_map_pkg::IDX_CONFIG_WORD, cfg(m));
				cv[15] <= x;
				wr(ref_map_pkg::IDX_REMOTE_REFERENCE, x ^ 16'h5A5A);
				cmd(want(m, x, nv));
				check({30'h0, control_mode}, 32'(m));
				rdw(ref_map_pkg::IDX_ACTIVE_CONFIG, cfg(m));
				if (m == 1)
				begin
					lost <= 1'b1;
					repeat (6) @(posedge ref_clk);
					cmd(LOST_CMD);
					lost <= 1'b0;
					cv[15] <= lim + 16'h1;
					repeat (6) @(posedge ref_clk);
					cmd(lim);
				end
				if (m == 2)
				begin
					nv = 16'($urandom);
					wr(ref_map_pkg::IDX_NV_REFERENCE, nv);
					cmd(nv);
				end
				rdw(ref_map_pkg::IDX_REMOTE_REFERENCE, (m == 2) ? nv : x ^ 16'h5A5A);
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
